/* File: inc/ipc_pkg.sv */
// package: register map, field layout and timing counts of the irq block
package ipc_pkg;
  localparam logic [11:0] OFS_GLOBAL_STATE = 12'h04C;
  localparam logic [11:0] OFS_FAST_ZERO = 12'h060;
  localparam logic [11:0] OFS_FAST_ONE = 12'h064;
  localparam logic [11:0] OFS_LOCKED_CFG = 12'h048;
  localparam logic [11:0] OFS_FAST_NUMBERS = 12'h050;
  localparam logic [11:0] OFS_SYS_CTRL = 12'h054;
  localparam logic [11:0] OFS_EVT_STATUS = 12'h070;
  localparam logic [11:0] OFS_EVT_MASK = 12'h074;
  localparam logic [15:0] UNLOCK_VALUE_ONE = 16'hFA05;
  localparam logic [15:0] UNLOCK_VALUE_TWO = 16'hBCAF;
  localparam logic [15:0] UNLOCK_VALUE_THREE = 16'hBEEF;
  localparam int RESET_REQUEST_BIT = 7;
  localparam int SYSTEM_RESET_BIT = 31;
  localparam int ANY_PENDING_BIT = 9;
  localparam int ANY_ACTIVE_BIT = 8;
  localparam logic [7:0] NEST_ONE = 8'h01;
  localparam logic [7:0] NEST_TWO = 8'h03;
  localparam logic [7:0] NEST_NONE = 8'h00;
  localparam int NEST_DEPTH = 2;
  localparam int SYSTEM_RESET_BIT_NS = 20;
  localparam int CLK_NS = 4;
  localparam int SYSTEM_RESET_BIT_CYC = (SYSTEM_RESET_BIT_NS + CLK_NS - 1) / CLK_NS;
  localparam int EVT_BITS = 3;
  localparam int EVT_FAST = 0;
  localparam int EVT_BAD_KEY = 1;
  localparam int EVT_OVERFLOW = 2;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // one fast-vector channel as the core sees it
  typedef struct packed {
    logic [7:0] irq_number;
    logic [30:0] handler_hi;
    logic enable;
  } ipc_fast_t;

  // core-side handshake of an interrupt being taken
  typedef struct packed {
    logic take;
    logic [7:0] number;
    logic ret;
  } ipc_core_evt_t;
endpackage : ipc_pkg

/* File: hw/ipc_top.sv */
// irq controller config, global status and fast vector channels
`timescale 1ns/1ns
module ipc_top #(
  parameter int IRQ_COUNT = 39
) (
  input wire logic clk_sys, // system clock
  input wire logic arst_n, // async reset
  input wire logic [11:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [11:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire logic [IRQ_COUNT-1:0] irq_pending, // pending lines, same clock
  input wire logic irq_take, // core enters a handler, pulse
  input wire logic [7:0] irq_take_number, // number being taken
  input wire logic irq_return, // core returns from a handler, pulse
  output logic fast_hit_ff, // taken irq matches a fast channel
  output logic [31:0] fast_target_ff, // handler address for fast hit
  output logic sys_reset_req_ff, // system reset request, high pulse
  output logic irq_out_ff // block event interrupt
);
  //////////////////////////////////////////////////////////////////////////
  // register state
  logic [15:0] fast_numbers_ff;
  logic [31:0] fast_zero_ff;
  logic [31:0] fast_one_ff;
  logic [1:0] nest_ff;
  logic [7:0] stack_ff [ipc_pkg::NEST_DEPTH];
  logic any_pending_ff;
  logic [ipc_pkg::EVT_BITS-1:0] evt_status_ff;
  logic [ipc_pkg::EVT_BITS-1:0] evt_mask_ff;
  logic [7:0] rst_cnt_ff;
  logic [11:0] aw_addr_ff;
  logic aw_have_ff;
  logic [31:0] w_data_ff;
  logic [3:0] w_strb_ff;
  logic w_have_ff;

  // decodes an offset into a known register
  function automatic logic is_mapped(input logic [11:0] a);
    is_mapped = (a == ipc_pkg::OFS_GLOBAL_STATE) ||
      (a == ipc_pkg::OFS_FAST_ZERO) || (a == ipc_pkg::OFS_FAST_ONE) ||
      (a == ipc_pkg::OFS_LOCKED_CFG) || (a == ipc_pkg::OFS_FAST_NUMBERS) ||
      (a == ipc_pkg::OFS_SYS_CTRL) || (a == ipc_pkg::OFS_EVT_STATUS) ||
      (a == ipc_pkg::OFS_EVT_MASK);
  endfunction : is_mapped

  // merges write data into a word under byte strobes
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] d,
                                        input logic [3:0] s);
    for (int i = 0; i < 4; i++)
    begin
      merge[i*8 +: 8] = s[i] ? d[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction : merge

  //////////////////////////////////////////////////////////////////////////
  // write channel: address and data accepted in either order
  logic wr_fire;
  assign wr_fire = aw_have_ff && w_have_ff && !s_axi_bvalid;

  // holds each write half until both are in
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      aw_have_ff <= 1'b0;
      w_have_ff <= 1'b0;
      aw_addr_ff <= 12'h000;
      w_data_ff <= 32'h0000_0000;
      w_strb_ff <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_have_ff <= 1'b1;
        aw_addr_ff <= {s_axi_awaddr[11:2], 2'b00};
      end
      else if (wr_fire)
        aw_have_ff <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_have_ff <= 1'b1;
        w_data_ff <= s_axi_wdata;
        w_strb_ff <= s_axi_wstrb;
      end
      else if (wr_fire)
        w_have_ff <= 1'b0;
    end
  end

  // ready only when the holding slot is free
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end
    else
    begin
      s_axi_awready <= !aw_have_ff && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready <= !w_have_ff && !(s_axi_wvalid && s_axi_wready);
    end
  end

  // write response one cycle after both halves are in
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= ipc_pkg::RESP_OKAY;
    end
    else if (wr_fire)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= is_mapped(aw_addr_ff) ? ipc_pkg::RESP_OKAY :
        ipc_pkg::RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////
  // decoded write strobes
  logic wr_cfg, wr_sctl, key_ok, sys_rst_hit, bad_key;
  assign wr_cfg = wr_fire && aw_addr_ff == ipc_pkg::OFS_LOCKED_CFG;
  assign wr_sctl = wr_fire && aw_addr_ff == ipc_pkg::OFS_SYS_CTRL;
  // key must arrive in the same write as the request bit
  assign key_ok = (&w_strb_ff[3:2]) &&
    w_data_ff[31:16] == ipc_pkg::UNLOCK_VALUE_THREE;
  // writing zero never triggers anything
  assign sys_rst_hit = key_ok && ((wr_cfg &&
    w_data_ff[ipc_pkg::RESET_REQUEST_BIT] && w_strb_ff[0]) ||
    (wr_sctl && w_data_ff[ipc_pkg::SYSTEM_RESET_BIT]));
  // wrong key on a protected bit is ignored but flagged
  assign bad_key = !key_ok && ((wr_cfg && w_strb_ff[0] &&
    w_data_ff[ipc_pkg::RESET_REQUEST_BIT]) ||
    (wr_sctl && w_data_ff[ipc_pkg::SYSTEM_RESET_BIT]));

  // reset request pulse, self-clearing, never readable as set
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rst_cnt_ff <= 8'h00;
      sys_reset_req_ff <= 1'b0;
    end
    else if (sys_rst_hit)
    begin
      rst_cnt_ff <= 8'(ipc_pkg::SYSTEM_RESET_BIT_CYC);
      sys_reset_req_ff <= 1'b1;
    end
    else if (rst_cnt_ff > 8'h01)
      rst_cnt_ff <= rst_cnt_ff - 8'h01;
    else
    begin
      rst_cnt_ff <= 8'h00;
      sys_reset_req_ff <= 1'b0;
    end
  end

  // fast channel configuration registers
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      fast_numbers_ff <= 16'h0000;
      fast_zero_ff <= 32'h0000_0000;
      fast_one_ff <= 32'h0000_0000;
    end
    else if (wr_fire)
    begin
      case (aw_addr_ff)
        ipc_pkg::OFS_FAST_NUMBERS:
          fast_numbers_ff <= 16'(merge({16'h0000, fast_numbers_ff},
            w_data_ff, w_strb_ff));
        ipc_pkg::OFS_FAST_ZERO:
          fast_zero_ff <= merge(fast_zero_ff, w_data_ff, w_strb_ff);
        ipc_pkg::OFS_FAST_ONE:
          fast_one_ff <= merge(fast_one_ff, w_data_ff, w_strb_ff);
        default:
          fast_numbers_ff <= fast_numbers_ff;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // nesting tracker with two-entry context stack
  logic push, pop, overflow;
  assign push = irq_take && nest_ff != 2'd2;
  assign overflow = irq_take && nest_ff == 2'd2;
  assign pop = irq_return && !irq_take && nest_ff != 2'd0;

  // a third level is refused; the core must not nest deeper
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      nest_ff <= 2'd0;
      for (int i = 0; i < ipc_pkg::NEST_DEPTH; i++)
        stack_ff[i] <= 8'h00;
    end
    else if (push)
    begin
      nest_ff <= nest_ff + 2'd1;
      stack_ff[nest_ff[0]] <= irq_take_number;
    end
    else if (pop)
      nest_ff <= nest_ff - 2'd1;
  end

  // one-cycle registered view of pending lines
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      any_pending_ff <= 1'b0;
    else
      any_pending_ff <= |irq_pending;
  end

  // fast vector lookup bypasses the vector table
  ipc_pkg::ipc_fast_t ch0, ch1;
  assign ch0 = '{fast_numbers_ff[7:0], fast_zero_ff[31:1], fast_zero_ff[0]};
  assign ch1 = '{fast_numbers_ff[15:8], fast_one_ff[31:1], fast_one_ff[0]};

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      fast_hit_ff <= 1'b0;
      fast_target_ff <= 32'h0000_0000;
    end
    else if (push && ch0.enable && irq_take_number == ch0.irq_number)
    begin
      fast_hit_ff <= 1'b1;
      fast_target_ff <= {ch0.handler_hi, 1'b0};
    end
    else if (push && ch1.enable && irq_take_number == ch1.irq_number)
    begin
      fast_hit_ff <= 1'b1;
      fast_target_ff <= {ch1.handler_hi, 1'b0};
    end
    else
      fast_hit_ff <= 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////
  // event status: set wins over write-one-to-clear
  logic [ipc_pkg::EVT_BITS-1:0] evt_set, evt_clr;
  assign evt_set = {overflow, bad_key, fast_hit_ff};
  assign evt_clr = (wr_fire && aw_addr_ff == ipc_pkg::OFS_EVT_STATUS &&
    w_strb_ff[0]) ? w_data_ff[ipc_pkg::EVT_BITS-1:0] : '0;

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      evt_status_ff <= '0;
      evt_mask_ff <= '0;
      irq_out_ff <= 1'b0;
    end
    else
    begin
      evt_status_ff <= (evt_status_ff & ~evt_clr) | evt_set;
      if (wr_fire && aw_addr_ff == ipc_pkg::OFS_EVT_MASK && w_strb_ff[0])
        evt_mask_ff <= w_data_ff[ipc_pkg::EVT_BITS-1:0];
      irq_out_ff <= |(evt_status_ff & evt_mask_ff);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // read channel, answer one cycle after the address
  logic [7:0] nest_code;
  assign nest_code = nest_ff == 2'd2 ? ipc_pkg::NEST_TWO :
    nest_ff == 2'd1 ? ipc_pkg::NEST_ONE : ipc_pkg::NEST_NONE;

  logic [31:0] rd_mux;
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    case ({s_axi_araddr[11:2], 2'b00})
      ipc_pkg::OFS_GLOBAL_STATE:
      begin
        rd_mux[7:0] = nest_code;
        rd_mux[ipc_pkg::ANY_ACTIVE_BIT] = nest_ff != 2'd0;
        rd_mux[ipc_pkg::ANY_PENDING_BIT] = any_pending_ff;
      end
      ipc_pkg::OFS_FAST_NUMBERS: rd_mux[15:0] = fast_numbers_ff;
      ipc_pkg::OFS_FAST_ZERO: rd_mux = fast_zero_ff;
      ipc_pkg::OFS_FAST_ONE: rd_mux = fast_one_ff;
      ipc_pkg::OFS_EVT_STATUS: rd_mux[ipc_pkg::EVT_BITS-1:0] = evt_status_ff;
      ipc_pkg::OFS_EVT_MASK: rd_mux[ipc_pkg::EVT_BITS-1:0] = evt_mask_ff;
      // unlock word and request bits are write-only, read zero
      ipc_pkg::OFS_LOCKED_CFG: rd_mux = 32'h0000_0000;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // one read at a time; arready drops while rvalid waits
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= ipc_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux;
      s_axi_rresp <= is_mapped({s_axi_araddr[11:2], 2'b00}) ?
        ipc_pkg::RESP_OKAY : ipc_pkg::RESP_SLVERR;
    end
    else if (s_axi_rvalid)
    begin
      if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
    else
      s_axi_arready <= 1'b1;
  end
endmodule : ipc_top

/* File: verification/ipc_props.sv */
// checker: port-level properties of the irq config and fast vector block
`timescale 1ns/1ns
module ipc_props #(
  parameter int IRQ_COUNT = 39
) (
  input wire logic clk_sys, // system clock
  input wire logic arst_n, // async reset
  input wire logic [11:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  input wire logic s_axi_arready, // read address ready
  input wire logic [31:0] s_axi_rdata, // read data
  input wire logic s_axi_bvalid, // write response valid
  input wire logic [IRQ_COUNT-1:0] irq_pending, // pending lines
  input wire logic irq_take, // handler entry
  input wire logic fast_hit_ff, // fast channel hit
  input wire logic [31:0] fast_target_ff, // fast handler address
  input wire logic sys_reset_req_ff // reset request pulse
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  ////////////////////////////////////////////////////////////////////////////
  // read data returns one cycle after the address is taken
  logic st_rd;
  logic cfg_rd;
  assign st_rd = s_axi_arvalid && s_axi_arready
    && s_axi_araddr == ipc_pkg::OFS_GLOBAL_STATE;
  assign cfg_rd = s_axi_arvalid && s_axi_arready
    && s_axi_araddr == ipc_pkg::OFS_LOCKED_CFG;
  ////////////////////////////////////////////////////////////////////////////
  rst_pulse_a: assert property (
    $rose(sys_reset_req_ff) |-> sys_reset_req_ff[*5] ##1 !sys_reset_req_ff)
    else $error("reset request pulse has wrong length");
  rst_cause_a: assert property (
    $rose(sys_reset_req_ff) |-> $rose(s_axi_bvalid))
    else $error("reset request without a write response");
  hit_cause_a: assert property (
    fast_hit_ff |-> $past(irq_take))
    else $error("fast hit without a taken interrupt");
  target_even_a: assert property (
    fast_hit_ff |-> fast_target_ff[0] == 1'h0)
    else $error("fast handler address is odd");
  key_hidden_a: assert property (
    cfg_rd |=> s_axi_rdata[31:16] == 16'h0000)
    else $error("unlock word readable");
  nest_code_a: assert property (
    st_rd |=> s_axi_rdata[7:0] inside {8'h00, 8'h01, 8'h03})
    else $error("bad nesting code");
  active_flag_a: assert property (
    st_rd |=> s_axi_rdata[8] == (s_axi_rdata[7:0] != 8'h00))
    else $error("active flag disagrees with nesting");
  pend_flag_a: assert property (
    st_rd && $stable(irq_pending) |=> s_axi_rdata[9] == |$past(irq_pending, 2))
    else $error("pending flag disagrees with pending lines");
  // main scenarios reached
  cover property ($rose(sys_reset_req_ff));
  cover property (fast_hit_ff);
  cover property (st_rd ##1 s_axi_rdata[7:0] == 8'h03);
endmodule : ipc_props

/* File: verification/ipc_core_model.sv */
// partner: core and request sources driving the irq block's event inputs
`timescale 1ns/1ns
module ipc_core_model #(
  parameter int IRQ_COUNT = 39
) (
  input wire logic clk_sys, // system clock
  input wire logic arst_n, // async reset
  input wire logic req_take, // enter a handler
  input wire logic req_ret, // leave a handler
  input wire logic [7:0] req_num, // number to enter
  input wire logic [IRQ_COUNT-1:0] req_pend, // pending sources
  output logic [IRQ_COUNT-1:0] pend_ff, // pending lines
  output logic take_ff, // entry pulse
  output logic [7:0] num_ff, // entry number
  output logic ret_ff // return pulse
);
  // one cycle of core latency; number line is junk outside a take
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pend_ff <= '0;
      take_ff <= 1'h0;
      num_ff <= 8'h00;
      ret_ff <= 1'h0;
    end
    else
    begin
      pend_ff <= req_pend;
      take_ff <= req_take;
      ret_ff <= req_ret && !req_take;
      num_ff <= req_take ? req_num : ~num_ff;
    end
  end
endmodule : ipc_core_model

/* File: verification/ipc_top_bench.sv */
// testbench: register map, reset request, events and fast vectors
`timescale 1ns/1ns
module ipc_top_bench;
  localparam int NIRQ = 39;
  typedef struct packed {
    logic [11:0] a;
    logic [31:0] d;
    logic [31:0] e;
    logic [1:0] r;
  } ipc_row_t;
  logic clk_sys = 1'h0;
  logic arst_n = 1'h0;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic arvalid = 1'h0, rready = 1'h0;
  logic take = 1'h0, ret = 1'h0;
  logic [7:0] num = 8'h00;
  logic [NIRQ-1:0] pend = '0;
  logic [3:0] strb = 4'hF;
  logic awready, wready, bvalid, arready, rvalid, hit, rst_req, irq_out;
  logic take_w, ret_w;
  logic [7:0] num_w;
  logic [NIRQ-1:0] pend_w;
  logic [1:0] bresp, rresp, rsp;
  logic [31:0] rdata, tgt, got, hit_tgt;
  int err_count = 0, check_count = 0, rst_cyc = 0, hits = 0;
  ipc_row_t rows [6];
  always #2 clk_sys = ~clk_sys;
  ////////////////////////////////////////////////////////////////////////////
  ipc_top #(.IRQ_COUNT(NIRQ)) dut (
    .clk_sys(clk_sys), .arst_n(arst_n), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(strb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .irq_pending(pend_w), .irq_take(take_w),
    .irq_take_number(num_w), .irq_return(ret_w), .fast_hit_ff(hit),
    .fast_target_ff(tgt), .sys_reset_req_ff(rst_req), .irq_out_ff(irq_out));
  ipc_core_model #(.IRQ_COUNT(NIRQ)) core_i (
    .clk_sys(clk_sys), .arst_n(arst_n), .req_take(take), .req_ret(ret),
    .req_num(num), .req_pend(pend), .pend_ff(pend_w), .take_ff(take_w),
    .num_ff(num_w), .ret_ff(ret_w));
  // count reset request cycles and capture fast hits
  always @(posedge clk_sys)
  begin
    if (rst_req === 1'h1) rst_cyc++;
    if (hit === 1'h1)
    begin
      hits++;
      hit_tgt = tgt;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e)
    begin
      err_count++;
      $display("[FAIL] %0t got %h want %h", $time, g, e);
    end
  endtask : chk
  // bus tasks: hold each channel until its ready; only the watchdog ends a wait
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do
    begin
      @(posedge clk_sys);
      if (awready === 1'h1) awvalid <= 1'h0;
      if (wready === 1'h1) wvalid <= 1'h0;
    end while (bvalid !== 1'h1);
    bready <= 1'h0;
    rsp = bresp;
    chk({31'h0, bvalid}, 32'h1);
  endtask : wr
  task automatic rd(input logic [11:0] a);
    @(posedge clk_sys);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do
    begin
      @(posedge clk_sys);
      if (arready === 1'h1) arvalid <= 1'h0;
    end while (rvalid !== 1'h1);
    rready <= 1'h0;
    got = rdata;
    rsp = rresp;
    chk({31'h0, rvalid}, 32'h1);
  endtask : rd
  task automatic core(input logic t, input logic r, input logic [7:0] n);
    @(posedge clk_sys);
    take <= t;
    ret <= r;
    num <= n;
    @(posedge clk_sys);
    take <= 1'h0;
    ret <= 1'h0;
    repeat (3) @(posedge clk_sys);
  endtask : core
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : conclude
  ////////////////////////////////////////////////////////////////////////////
  // main sequence: table rows first, awkward cases after
  initial
  begin
    rows = '{'{ipc_pkg::OFS_FAST_ZERO, 32'h12345679, 32'h12345679, 2'h0},
      '{ipc_pkg::OFS_FAST_ONE, 32'hCAFE0001, 32'hCAFE0001, 2'h0},
      '{ipc_pkg::OFS_FAST_NUMBERS, 32'hFFFF2A05, 32'h00002A05, 2'h0},
      '{ipc_pkg::OFS_LOCKED_CFG, 32'h12340000, 32'h0, 2'h0},
      '{ipc_pkg::OFS_GLOBAL_STATE, 32'hFFFFFFFF, 32'h0, 2'h0},
      '{12'h0F0, 32'hFFFFFFFF, 32'h0, ipc_pkg::RESP_SLVERR}};
    repeat (3) @(posedge clk_sys);
    arst_n <= 1'h1;
    for (int i = 0; i < 5; i++)
    begin
      rd(rows[i].a);
      chk(got, 32'h0);
    end
    $display("reset values done");
    foreach (rows[i])
    begin
      wr(rows[i].a, rows[i].d);
      chk({30'h0, rsp}, {30'h0, rows[i].r});
      rd(rows[i].a);
      chk(got, rows[i].e);
      chk({30'h0, rsp}, {30'h0, rows[i].r});
    end
    $display("register table done");
    wr(ipc_pkg::OFS_EVT_MASK, 32'h0);
    wr(ipc_pkg::OFS_EVT_STATUS, 32'h7);
    wr(ipc_pkg::OFS_LOCKED_CFG, 32'h12340080);
    wr(ipc_pkg::OFS_LOCKED_CFG, 32'hBEEF0000);
    repeat (8) @(posedge clk_sys);
    chk(rst_cyc, 0);
    rd(ipc_pkg::OFS_EVT_STATUS);
    chk(got, 32'h2);
    chk({31'h0, irq_out}, 32'h0);
    wr(ipc_pkg::OFS_EVT_MASK, 32'h2);
    repeat (3) @(posedge clk_sys);
    chk({31'h0, irq_out}, 32'h1);
    wr(ipc_pkg::OFS_EVT_STATUS, 32'h2);
    repeat (3) @(posedge clk_sys);
    chk({31'h0, irq_out}, 32'h0);
    wr(ipc_pkg::OFS_LOCKED_CFG, 32'hBEEF0080);
    repeat (8) @(posedge clk_sys);
    chk(rst_cyc, 5);
    rd(ipc_pkg::OFS_LOCKED_CFG);
    chk(got, 32'h0);
    wr(ipc_pkg::OFS_SYS_CTRL, 32'hBEEF0000);
    repeat (8) @(posedge clk_sys);
    chk(rst_cyc, 10);
    $display("reset request and events done");
    wr(ipc_pkg::OFS_EVT_STATUS, 32'h7);
    wr(ipc_pkg::OFS_FAST_NUMBERS, 32'h00000905);
    wr(ipc_pkg::OFS_FAST_ZERO, 32'h00001001);
    wr(ipc_pkg::OFS_FAST_ONE, 32'h00002000);
    core(1'h1, 1'h0, 8'h05);
    chk(hits, 1);
    chk(hit_tgt, 32'h1000);
    core(1'h1, 1'h0, 8'h09);
    chk(hits, 1);
    rd(ipc_pkg::OFS_GLOBAL_STATE);
    chk(got, 32'h103);
    core(1'h1, 1'h0, 8'h07);
    rd(ipc_pkg::OFS_GLOBAL_STATE);
    chk(got, 32'h103);
    core(1'h0, 1'h1, 8'h00);
    rd(ipc_pkg::OFS_GLOBAL_STATE);
    chk(got, 32'h101);
    pend <= {1'h1, 38'h0};
    core(1'h0, 1'h1, 8'h00);
    rd(ipc_pkg::OFS_GLOBAL_STATE);
    chk(got, 32'h200);
    pend <= '0;
    wr(ipc_pkg::OFS_FAST_ONE, 32'h00002001);
    core(1'h1, 1'h0, 8'h09);
    chk(hits, 2);
    chk(hit_tgt, 32'h2000);
    core(1'h0, 1'h1, 8'h00);
    // byte strobes: only the low number byte may change
    strb <= 4'h1;
    wr(ipc_pkg::OFS_FAST_NUMBERS, 32'hFFFF3377);
    rd(ipc_pkg::OFS_FAST_NUMBERS);
    chk(got, 32'h0977);
    rd(ipc_pkg::OFS_EVT_STATUS);
    chk(got, 32'h5);
    // key bytes not strobed, so the request must be ignored
    wr(ipc_pkg::OFS_LOCKED_CFG, 32'hBEEF0080);
    repeat (8) @(posedge clk_sys);
    chk(rst_cyc, 10);
    strb <= 4'hF;
    $display("fast vectors and nesting done");
    // mid-run reset brings the fast channels back to off
    arst_n <= 1'h0;
    repeat (3) @(posedge clk_sys);
    arst_n <= 1'h1;
    for (int i = 0; i < 3; i++)
    begin
      rd(rows[i].a);
      chk(got, 32'h0);
    end
    $display("mid-run reset done");
    conclude();
  end
  // watchdog far beyond the expected run
  initial
  begin
    repeat (5000) @(posedge clk_sys);
    $display("[FAIL] %0t watchdog expired", $time);
    err_count++;
    conclude();
  end
endmodule : ipc_top_bench
bind ipc_top ipc_props #(.IRQ_COUNT(IRQ_COUNT)) props (
  .clk_sys(clk_sys), .arst_n(arst_n), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_bvalid(s_axi_bvalid),
  .irq_pending(irq_pending), .irq_take(irq_take), .fast_hit_ff(fast_hit_ff),
  .fast_target_ff(fast_target_ff), .sys_reset_req_ff(sys_reset_req_ff));
